/* File: rtl/layout_pkg.sv */
// shared constants and types for the surface layout calculator
`default_nettype none

package layout_pkg;

  // faces in memory order, array element 0 first
  typedef enum logic [2:0] {
    face_pos_x,
    face_neg_x,
    face_pos_y,
    face_neg_y,
    face_pos_z,
    face_neg_z
  } face_e;

  // kind of surface being walked
  typedef enum logic [1:0] {
    surf_2d,
    surf_cube,
    surf_volume
  } surf_kind_e;

  localparam int CUBE_FACES = 6;
  localparam int DIM_MIN = 1;
  localparam int ALIGN_W = 3;
  localparam int BPT_W = 6;
  localparam int ROWS_W = 2;
  localparam logic [ALIGN_W-1:0] COMP_VALIGN_LOG2 = 3'h2;
  localparam logic [ROWS_W-1:0] ROWS_LOG2_RESET = 2'h0;

endpackage

`default_nettype wire

/* File: rtl/level_dims.sv */
// per-level width, height, depth and aligned footprint
`timescale 1ns/1ps
`default_nettype none

module level_dims
  import layout_pkg::*;
#(
  parameter int DIM_W = 14,
  parameter int LVL_W = 4
) (
  input wire logic [DIM_W-1:0] width,
  input wire logic [DIM_W-1:0] height,
  input wire logic [DIM_W-1:0] depth,
  input wire logic [LVL_W-1:0] level,
  input wire logic [ALIGN_W-1:0] halign_log2,
  input wire logic [ALIGN_W-1:0] valign_log2,
  output logic [DIM_W-1:0] dim_w,
  output logic [DIM_W-1:0] dim_h,
  output logic [DIM_W-1:0] dim_d,
  output logic [DIM_W-1:0] al_w,
  output logic [DIM_W-1:0] al_h
);

  localparam logic [DIM_W-1:0] ONE = DIM_W'(DIM_MIN);

  logic [DIM_W-1:0] sw;
  logic [DIM_W-1:0] sh;
  logic [DIM_W-1:0] sd;
  logic [DIM_W-1:0] hmask;
  logic [DIM_W-1:0] vmask;

  // shifted dimensions, never below one
  assign sw = width >> level;
  assign sh = height >> level;
  assign sd = depth >> level;
  assign dim_w = (sw != '0) ? sw : ONE;
  assign dim_h = (sh != '0) ? sh : ONE;
  assign dim_d = (sd != '0) ? sd : ONE;

  // round up to alignment unit, depth left unaligned
  assign hmask = DIM_W'((1 << halign_log2) - 1);
  assign vmask = DIM_W'((1 << valign_log2) - 1);
  assign al_w = (dim_w + hmask) & ~hmask;
  assign al_h = (dim_h + vmask) & ~vmask;

endmodule

`default_nettype wire

/* File: rtl/surface_layout.sv */
// cube, array and volume surface layout and fetch check
`timescale 1ns/1ps
`default_nettype none

// Operation
// - cube is a six-element 2D array
// - elements 0..5 hold +x,-x,+y,-y,+z,-z
// - one cube layout regardless of faces, levels
// - six consecutive elements form one cube
// - volume levels stacked, planes 2^L per row
// - level dimension is base shifted, minimum one
// - align width and height, never depth
// - plane origin from modulo column, summed rows
// - mip placement offsets added to plane origin
// - whole line fetched, outside texels excluded, errors
// - data port fetches right-of-surface pixels, flags errors
// - address is base plus row and column bytes
module surface_layout
  import layout_pkg::*;
#(
  parameter int DIM_W = 14,
  parameter int LVL_W = 4,
  parameter int MAX_LEVELS = 15,
  parameter int Y_W = 24,
  parameter int ADDR_W = 32,
  parameter int PITCH_W = 18,
  parameter int LINE_BYTES = 64
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic [1:0] surf_kind,
  input wire logic [DIM_W-1:0] base_width,
  input wire logic [DIM_W-1:0] base_height,
  input wire logic [DIM_W-1:0] base_depth,
  input wire logic [LVL_W-1:0] level,
  input wire logic [ALIGN_W-1:0] halign_log2,
  input wire logic [ALIGN_W-1:0] valign_log2,
  input wire logic compressed,
  input wire logic [DIM_W-1:0] array_index,
  input wire logic [2:0] face,
  input wire logic [Y_W-1:0] qpitch,
  input wire logic [Y_W-1:0] mip_x,
  input wire logic [Y_W-1:0] mip_y,
  input wire logic [DIM_W-1:0] texel_u,
  input wire logic [DIM_W-1:0] texel_v,
  input wire logic [ADDR_W-1:0] base_addr,
  input wire logic [PITCH_W-1:0] pitch,
  input wire logic [BPT_W-1:0] bpt_half,
  input wire logic [ROWS_W-1:0] rows_log2,
  input wire logic dataport,
  input wire logic [ADDR_W-1:0] mapped_lo,
  input wire logic [ADDR_W-1:0] mapped_hi,
  output logic out_valid,
  output logic [Y_W-1:0] out_x,
  output logic [Y_W-1:0] out_y,
  output logic [ADDR_W-1:0] out_addr,
  output logic [ADDR_W-1:0] out_line_addr,
  output logic out_excluded,
  output logic out_xlate_err
);

  // line mask and product width follow from the parameters
  localparam int PROD_W = Y_W + PITCH_W;
  localparam logic [ADDR_W-1:0] LINE_MASK = ADDR_W'(LINE_BYTES - 1);
  localparam logic [DIM_W-1:0] FACES = DIM_W'(CUBE_FACES);

  ////////////////////////////////////////////////////////////////////
  // level geometry

  logic [ALIGN_W-1:0] valign_eff;
  logic [DIM_W-1:0] lw;
  logic [DIM_W-1:0] lh;
  logic [DIM_W-1:0] law;
  logic [DIM_W-1:0] lah;

  // compressed formats always place levels on four-row units
  assign valign_eff = compressed ? COMP_VALIGN_LOG2 : valign_log2;

  // dimensions of the requested level
  level_dims #(
    .DIM_W(DIM_W),
    .LVL_W(LVL_W)
  ) u_req_dims (
    .width(base_width),
    .height(base_height),
    .depth(base_depth),
    .level(level),
    .halign_log2(halign_log2),
    .valign_log2(valign_eff),
    .dim_w(lw),
    .dim_h(lh),
    .dim_d(),
    .al_w(law),
    .al_h(lah)
  );

  ////////////////////////////////////////////////////////////////////
  // volume row prefix: rows taken by every level above the request

  // row_sum[k] counts the rows used by every level before both k and the request
  logic [Y_W-1:0] row_sum [0:MAX_LEVELS];

  // level zero starts at the top of the volume
  assign row_sum[0] = '0;

  genvar k;
  generate
    for (k = 0; k < MAX_LEVELS; k = k + 1) begin : g_lvl
      logic [DIM_W-1:0] kd;
      logic [DIM_W-1:0] kah;
      logic [DIM_W:0] kround;
      logic [DIM_W:0] krows;
      logic [2*DIM_W:0] kspan;
      logic kbefore;

      level_dims #(
        .DIM_W(DIM_W),
        .LVL_W(LVL_W)
      ) u_dims (
        .width(base_width),
        .height(base_height),
        .depth(base_depth),
        .level(LVL_W'(k)),
        .halign_log2(halign_log2),
        .valign_log2(valign_eff),
        .dim_w(),
        .dim_h(),
        .dim_d(kd),
        .al_w(),
        .al_h(kah)
      );

      // ceil(depth_k / 2^k) rows of planes, each one aligned height
      assign kround = (DIM_W+1)'((1 << k) - 1);
      assign krows = ({1'b0, kd} + kround) >> k;
      assign kspan = krows * kah;

      // levels at or past the request add nothing, so one chain
      // serves every requested level
      assign kbefore = (LVL_W'(k) < level);
      assign row_sum[k+1] = row_sum[k] +
        (kbefore ? Y_W'(kspan) : Y_W'(0));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // plane origin per surface kind

  logic [DIM_W-1:0] col_mask;
  logic [DIM_W-1:0] vol_col;
  logic [DIM_W-1:0] vol_row;
  logic [2*DIM_W-1:0] vol_x_p;
  logic [2*DIM_W-1:0] vol_y_p;
  logic [Y_W-1:0] vol_x;
  logic [Y_W-1:0] vol_y;

  // column is q mod 2^L, row is q >> L
  assign col_mask = DIM_W'((1 << level) - 1);
  assign vol_col = array_index & col_mask;
  assign vol_row = array_index >> level;
  assign vol_x_p = vol_col * law;
  assign vol_y_p = vol_row * lah;
  assign vol_x = Y_W'(vol_x_p);
  assign vol_y = row_sum[level] + Y_W'(vol_y_p);

  logic face_ok;
  logic [DIM_W-1:0] cube_elem;
  logic [DIM_W-1:0] elem;
  logic [Y_W+DIM_W-1:0] arr_y_p;
  logic [Y_W-1:0] arr_y;

  // a cube is six elements; face picks the element within it,
  // independent of which faces or levels are really in use;
  // a face code past the last one still forms an address but
  // the result is marked excluded
  assign face_ok = (face <= 3'(face_neg_z));
  assign cube_elem = array_index * FACES + DIM_W'(face);
  assign elem = (surf_kind == surf_cube) ? cube_elem
                                         : array_index;
  assign arr_y_p = elem * qpitch;
  assign arr_y = Y_W'(arr_y_p);

  logic kind_vol;
  logic kind_bad;
  logic [Y_W-1:0] org_x;
  logic [Y_W-1:0] org_y;

  // volumes take the stacked origin, arrays and cubes the slice
  // row; the spare kind code only marks the result excluded
  assign kind_vol = (surf_kind == surf_volume);
  assign kind_bad = (surf_kind > surf_volume);
  assign org_x = kind_vol ? vol_x : '0;
  assign org_y = kind_vol ? vol_y : arr_y;

  ////////////////////////////////////////////////////////////////////
  // texel coordinate and byte address

  logic [Y_W-1:0] tx;
  logic [Y_W-1:0] ty;

  // mip placement and texel offset on top of the plane origin;
  // sums wrap at the coordinate width
  assign tx = org_x + mip_x + Y_W'(texel_u);
  assign ty = org_y + mip_y + Y_W'(texel_v);

  logic [PROD_W-1:0] row_p;
  logic [PROD_W-1:0] row_bytes;
  logic [Y_W+BPT_W+3:0] col_p;
  logic [Y_W+BPT_W+3:0] col_bytes;
  logic [ADDR_W-1:0] addr;

  // bytes per texel held in half bytes for the 4-bit formats;
  // one texel size serves every face of a cube;
  // products stay full width so only the final sum wraps
  assign row_p = ty * pitch;
  assign row_bytes = row_p >> rows_log2;
  assign col_p = tx * bpt_half;
  assign col_bytes = (col_p << rows_log2) >> 1;
  assign addr = base_addr + ADDR_W'(row_bytes)
              + ADDR_W'(col_bytes);

  ////////////////////////////////////////////////////////////////////
  // cache line fetch and translation check

  logic [ADDR_W-1:0] line_addr;
  logic [ADDR_W-1:0] line_end;
  logic outside_x;
  logic outside_y;
  logic excluded;
  logic xlate_err;

  // the whole line is fetched even when part lies off the surface
  assign line_addr = addr & ~LINE_MASK;
  assign line_end = line_addr | LINE_MASK;

  // sampler drops texels right or below; data port only below;
  // the limits are the unaligned level sizes, not the padded ones
  assign outside_x = (texel_u >= lw) && !dataport;
  assign outside_y = (texel_v >= lh);
  assign excluded = outside_x || outside_y || kind_bad ||
                    ((surf_kind == surf_cube) && !face_ok);

  // any byte of the line outside mapped space is an error,
  // even when the texel itself lies inside the mapped window
  assign xlate_err = (line_addr < mapped_lo) ||
                     (line_end > mapped_hi);

  ////////////////////////////////////////////////////////////////////
  // output register stage

  logic valid_r;
  logic [Y_W-1:0] x_r;
  logic [Y_W-1:0] y_r;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] line_r;
  logic excl_r;
  logic err_r;

  // answer one clock after each accepted request;
  // data holds between requests so a slow reader still sees it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      valid_r <= 1'b0;
      x_r <= '0;
      y_r <= '0;
      addr_r <= '0;
      line_r <= '0;
      excl_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      valid_r <= req_valid;
      if (req_valid) begin
        x_r <= tx;
        y_r <= ty;
        addr_r <= addr;
        line_r <= line_addr;
        excl_r <= excluded;
        err_r <= xlate_err;
      end
    end
  end

  // outputs straight from the stage
  assign out_valid = valid_r;
  assign out_x = x_r;
  assign out_y = y_r;
  assign out_addr = addr_r;
  assign out_line_addr = line_r;
  assign out_excluded = excl_r;
  assign out_xlate_err = err_r;

endmodule

`default_nettype wire

/* File: sim/surface_layout_assertions.sv */
// port checks on the surface layout calculator
`timescale 1ns/1ps
`default_nettype none

module surface_layout_assertions
  import layout_pkg::*;
#(
  parameter int DIM_W = 14,
  parameter int LVL_W = 4,
  parameter int Y_W = 24,
  parameter int ADDR_W = 32,
  parameter int LINE_BYTES = 64
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic [1:0] surf_kind,
  input wire logic [DIM_W-1:0] base_width,
  input wire logic [LVL_W-1:0] level,
  input wire logic [2:0] face,
  input wire logic [Y_W-1:0] mip_x,
  input wire logic [DIM_W-1:0] texel_u,
  input wire logic dataport,
  input wire logic [ADDR_W-1:0] mapped_lo,
  input wire logic [ADDR_W-1:0] mapped_hi,
  input wire logic out_valid,
  input wire logic [Y_W-1:0] out_x,
  input wire logic [ADDR_W-1:0] out_addr,
  input wire logic [ADDR_W-1:0] out_line_addr,
  input wire logic out_excluded,
  input wire logic out_xlate_err
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // handshake and reset
  property p_pulse; 1 |=> out_valid == $past(req_valid); endproperty
  a_pulse: assert property (p_pulse) else $error("valid late");
  property p_rst;
    disable iff (1'b0) !resetn |=> !out_valid && out_addr == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not clear");
  property p_hold; !req_valid |=> $stable(out_addr) && $stable(out_x);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  ////////////////////////////////////////////////////////////////////////////
  // line fetch and translation check
  property p_line;
    out_valid |-> out_line_addr == (out_addr & ~ADDR_W'(LINE_BYTES - 1));
  endproperty
  a_line: assert property (p_line) else $error("line addr");
  property p_err;
    out_valid |-> out_xlate_err == (out_line_addr < $past(mapped_lo) ||
      (out_line_addr | ADDR_W'(LINE_BYTES - 1)) > $past(mapped_hi));
  endproperty
  a_err: assert property (p_err) else $error("xlate err");
  ////////////////////////////////////////////////////////////////////////////
  // exclusion and placement
  property p_face; req_valid && surf_kind == 2'h1 && face > 3'h5
    |=> out_excluded; endproperty
  a_face: assert property (p_face) else $error("bad face kept");
  property p_excl; req_valid && !dataport && level == 0 &&
    base_width != 0 && texel_u >= base_width |=> out_excluded; endproperty
  a_excl: assert property (p_excl) else $error("outside kept");
  property p_volx; req_valid && surf_kind == 2'h2 && level == 0
    |=> out_x == Y_W'($past(mip_x) + $past(texel_u)); endproperty
  a_volx: assert property (p_volx) else $error("plane x");
endmodule

bind surface_layout surface_layout_assertions #(.DIM_W(DIM_W),
  .LVL_W(LVL_W), .Y_W(Y_W), .ADDR_W(ADDR_W), .LINE_BYTES(LINE_BYTES))
  i_chk (.mclk, .resetn, .req_valid, .surf_kind, .base_width, .level,
  .face, .mip_x, .texel_u, .dataport, .mapped_lo, .mapped_hi, .out_valid,
  .out_x, .out_addr, .out_line_addr, .out_excluded, .out_xlate_err);

`default_nettype wire

/* File: sim/surface_layout_test.sv */
// self-checking bench for the surface layout calculator
`timescale 1ns/1ps
`default_nettype none

module surface_layout_test;
  import layout_pkg::*;
  logic mclk = 0, resetn = 0, req_valid = 0, compressed = 0, dataport = 0;
  logic full = 0, out_valid, out_excluded, out_xlate_err;
  logic [1:0] surf_kind = 0, rows_log2 = 0;
  logic [13:0] base_width = 1, base_height = 1, base_depth = 1;
  logic [13:0] array_index = 0, texel_u = 0, texel_v = 0;
  logic [3:0] level = 0;
  logic [2:0] halign_log2 = 0, valign_log2 = 0, face = 0;
  logic [23:0] qpitch = 0, mip_x = 0, mip_y = 0, out_x, out_y;
  logic [31:0] base_addr = 0, win_lo = 0, win_hi = 0, mapped_lo, mapped_hi;
  logic [31:0] out_addr, out_line_addr;
  logic [17:0] pitch = 0;
  logic [5:0] bpt_half = 1;
  int fail_count = 0, compares = 0;
  longint q_x[$], q_y[$], q_a[$], q_e[$], q_r[$], q_l[$];

  surface_layout i_dut (.mclk, .resetn, .req_valid, .surf_kind, .base_width,
    .base_height, .base_depth, .level, .halign_log2, .valign_log2,
    .compressed, .array_index, .face, .qpitch, .mip_x, .mip_y, .texel_u,
    .texel_v, .base_addr, .pitch, .bpt_half, .rows_log2, .dataport,
    .mapped_lo, .mapped_hi, .out_valid, .out_x, .out_y, .out_addr,
    .out_line_addr, .out_excluded, .out_xlate_err);
  tex_memory i_mem (.full, .win_lo, .win_hi, .mapped_lo, .mapped_hi);

  // clock
  initial forever #2.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  // reference model helpers
  function automatic longint dm(longint b, int k);
    return (b >> k) > 0 ? b >> k : 1;
  endfunction
  function automatic longint al(longint b, int k, int a);
    return ((dm(b, k) + (1 << a) - 1) >> a) << a;
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // result compare against model queue
  always @(negedge mclk) begin
    if (out_valid === 1'b1) begin
      if (q_x.size() == 0) chk(32'h1, 32'h0);
      else begin
        chk(out_x, q_x.pop_front());
        chk(out_y, q_y.pop_front());
        chk(out_addr, q_a.pop_front());
        chk(out_line_addr, q_l.pop_front());
        chk(out_excluded, q_e.pop_front());
        chk(out_xlate_err, q_r.pop_front());
      end
    end
  end
  // random back-to-back requests and model
  initial begin
    longint x, y, a, j, ln;
    void'($urandom(32'h599b809e));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk(out_addr, 32'h0);
    repeat (600) begin
      @(posedge mclk);
      req_valid <= $urandom_range(0, 3) != 0;
      surf_kind <= 2'($urandom_range(0, 3));
      base_width <= 14'($urandom_range(1, 255));
      base_height <= 14'($urandom_range(1, 255));
      base_depth <= 14'($urandom_range(1, 255));
      level <= 4'($urandom_range(0, 4));
      halign_log2 <= 3'($urandom_range(0, 4));
      valign_log2 <= 3'($urandom_range(0, 4));
      {compressed, dataport, full} <= 3'($urandom);
      array_index <= 14'($urandom_range(0, 15));
      face <= 3'($urandom_range(0, 7));
      qpitch <= 24'($urandom_range(0, 255));
      mip_x <= 24'($urandom_range(0, 255));
      mip_y <= 24'($urandom_range(0, 255));
      texel_u <= 14'($urandom_range(0, 255));
      texel_v <= 14'($urandom_range(0, 255));
      base_addr <= $urandom_range(0, 1 << 20);
      pitch <= 18'($urandom_range(0, 255));
      bpt_half <= 6'($urandom_range(1, 32));
      rows_log2 <= 2'($urandom_range(0, 1) * 2);
      win_lo <= $urandom_range(0, 1 << 21);
      win_hi <= $urandom_range(1 << 21, 1 << 24);
      #1;
      if (req_valid) begin
        j = compressed ? 2 : valign_log2;
        x = 0;
        y = (surf_kind == 1 ? array_index * 6 + face : array_index) * qpitch;
        if (surf_kind == 2) begin
          x = (array_index % (1 << level)) * al(base_width, level, halign_log2);
          y = (array_index >> level) * al(base_height, level, j);
          for (int k = 0; k < level; k++)
            y += (dm(base_depth, k) + (1 << k) - 1) / (1 << k) *
              al(base_height, k, j);
        end
        x = (x + mip_x + texel_u) & 24'hffffff;
        y = (y + mip_y + texel_v) & 24'hffffff;
        a = (base_addr + ((y * pitch) >> rows_log2) +
          (((x * bpt_half) << rows_log2) >> 1)) & 32'hffffffff;
        ln = a & 32'hffffffc0;
        q_x.push_back(x);
        q_y.push_back(y);
        q_a.push_back(a);
        q_l.push_back(ln);
        q_e.push_back((texel_u >= dm(base_width, level) && !dataport) ||
          texel_v >= dm(base_height, level) || surf_kind == 3 ||
          (surf_kind == 1 && face > 5));
        q_r.push_back(ln < mapped_lo || (ln | 63) > mapped_hi);
      end
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(q_x.size(), 32'h0);
    wrap_up();
  end
endmodule

`default_nettype wire

/* File: sim/tex_memory.sv */
// translated graphics memory window seen by the texel requester
`timescale 1ns/1ps
`default_nettype none

module tex_memory (
  input wire logic full,
  input wire logic [31:0] win_lo,
  input wire logic [31:0] win_hi,
  output logic [31:0] mapped_lo,
  output logic [31:0] mapped_hi
);
  // padded surface fully mapped, or one window of valid entries
  assign mapped_lo = full ? 32'h0 : win_lo;
  assign mapped_hi = full ? 32'hffffffff : win_hi;
endmodule

`default_nettype wire
